//--- poid_defs.vh
// Register offsets, field positions and reset values of the phase offset register bank
`ifndef POID_DEFS_VH
`define POID_DEFS_VH
// ==========================================================
// Register indexes; the byte address is the index times four
`define POID_IDX_UPPER      8'h06
`define POID_IDX_LOWER      8'h07
`define POID_IDX_IDENT      8'h0F
`define POID_ADDR_LSB       2
`define POID_ADDR_W         8
// ==========================================================
// Fields
`define POID_EN_BIT         3
`define POID_HI_MSB         2
`define POID_HI_W           3
`define POID_WORD_W         11
`define POID_UPPER_MASK     8'h0F
`define POID_UPPER_RST      8'h00
`define POID_LOWER_RST      8'h00
`define POID_WORD_RST       11'h000
// ==========================================================
// Bus answers and timing
`define POID_RESP_OKAY      2'b00
`define POID_RESP_SLVERR    2'b10
`define POID_STEP_PS        61035
`define POID_CLK_PS         20000
`endif

//--- poid_shift_track.v
// Phase shift tracker: follows the programmed offset word one step at a time
`include "poid_defs.vh"
module poid_shift_track #(
  parameter W = `POID_WORD_W
) (
  input  wire         clk_in,
  input  wire         rstn_in,
  input  wire         enable_in,
  input  wire [W-1:0] target_in,
  output reg  [W-1:0] applied_out,
  output reg          advance_out,
  output reg          retard_out
);
  // ==========================================================
  // Stepper
  // Moves one step per cycle so the core never sees a jump even if software skips values
  wire [W-1:0] goal = enable_in ? target_in : {W{1'b0}};  // R1
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      applied_out <= `POID_WORD_RST;
      advance_out <= 1'b0;
      retard_out  <= 1'b0;
    end else begin
      advance_out <= goal > applied_out;  // R4
      retard_out  <= goal < applied_out;  // R7
      if (goal > applied_out) begin
        applied_out <= applied_out + {{(W-1){1'b0}}, 1'b1};  // R4
      end else if (goal < applied_out) begin
        applied_out <= applied_out - {{(W-1){1'b0}}, 1'b1};  // R7
      end
    end
  end
endmodule

//--- poid_regs.v
// AXI4-Lite register bank for the phase offset and identification registers
// What the document requires
// (R1) Offset is applied to the generated clocks only while the enable bit is one. Here it ramps back to zero, one step per cycle, after the bit clears.
// (R2) Offset word is upper bits 2..0 above the eight lower-register bits.
// (R3) Offset word is unsigned, 0 to 2047, no sign bit.
// (R4) Each unit increase advances affected clocks by 61.035 ns.
// (R5) Offset shifts all 16 MHz derived clocks and frame pulses.
// (R6) Host changes the offset one step per write, each value in turn.
// (R7) Decreasing writes delay the clocks one step per write.
// (R8) Host should avoid changing offset while network clocks run.
// (R9) Identification bits 7..4 return the fixed part code.
// (R10) Identification bits 3..0 return the revision, starting at zero.
// (R11) Upper reserved bits read zero; offset registers read back written values.
//
// Register access over AXI4-Lite is this design's own decision.
`include "poid_defs.vh"
module poid_regs #(
  parameter [3:0] PART_ID  = 4'h5,  // Arbitrary value
  parameter [3:0] REV_ID   = 4'h0,
  parameter       WORD_W   = `POID_WORD_W
) (
  input  wire              CLK_SYS_IN,
  input  wire              RSTN_IN,
  input  wire [7:0]        S_AXI_AWADDR_IN,
  input  wire              S_AXI_AWVALID_IN,
  output reg               S_AXI_AWREADY_OUT,
  input  wire [31:0]       S_AXI_WDATA_IN,
  input  wire [3:0]        S_AXI_WSTRB_IN,
  input  wire              S_AXI_WVALID_IN,
  output reg               S_AXI_WREADY_OUT,
  output reg  [1:0]        S_AXI_BRESP_OUT,
  output reg               S_AXI_BVALID_OUT,
  input  wire              S_AXI_BREADY_IN,
  input  wire [7:0]        S_AXI_ARADDR_IN,
  input  wire              S_AXI_ARVALID_IN,
  output reg               S_AXI_ARREADY_OUT,
  output reg  [31:0]       S_AXI_RDATA_OUT,
  output reg  [1:0]        S_AXI_RRESP_OUT,
  output reg               S_AXI_RVALID_OUT,
  input  wire              S_AXI_RREADY_IN,
  output reg               PHASE_SHIFT_ENABLE_OUT,
  output reg  [WORD_W-1:0] SHIFT_WORD_OUT,
  output reg  [WORD_W-1:0] APPLIED_SHIFT_OUT,
  output reg               SHIFT_ADVANCE_OUT,
  output reg               SHIFT_RETARD_OUT
);
  // ==========================================================
  // Registers
  reg [7:0]  upper_r;
  reg [7:0]  lower_r;
  reg        aw_have_r;
  reg [7:0]  aw_addr_r;
  reg        w_have_r;
  reg [31:0] w_data_r;
  reg        w_strb0_r;
  wire [WORD_W-1:0] applied;
  wire              adv;
  wire              ret;
  wire [WORD_W-1:0] word = {upper_r[`POID_HI_MSB:0], lower_r};  // R2 R3
  wire [7:0] w_idx  = aw_addr_r >> `POID_ADDR_LSB;
  wire [7:0] r_idx  = S_AXI_ARADDR_IN >> `POID_ADDR_LSB;
  wire       do_wr  = aw_have_r && w_have_r && !S_AXI_BVALID_OUT;
  wire       w_ok   = (w_idx == `POID_IDX_UPPER) || (w_idx == `POID_IDX_LOWER);
  wire       do_rd  = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  // ==========================================================
  // Write channel: address and data taken in either order
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      aw_have_r         <= 1'b0;
      aw_addr_r         <= 8'h00;
      w_have_r          <= 1'b0;
      w_data_r          <= 32'h00000000;
      w_strb0_r         <= 1'b0;
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT  <= 1'b0;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= `POID_RESP_OKAY;
      upper_r           <= `POID_UPPER_RST;
      lower_r           <= `POID_LOWER_RST;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_have_r && !(S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT);
      S_AXI_WREADY_OUT  <= !w_have_r && !(S_AXI_WVALID_IN && S_AXI_WREADY_OUT);
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_have_r  <= 1'b1;
        w_data_r  <= S_AXI_WDATA_IN;
        w_strb0_r <= S_AXI_WSTRB_IN[0];
      end
      if (do_wr) begin
        aw_have_r        <= 1'b0;
        w_have_r         <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= w_ok ? `POID_RESP_OKAY : `POID_RESP_SLVERR;
        if (w_strb0_r && w_idx == `POID_IDX_UPPER) begin
          upper_r <= w_data_r[7:0] & `POID_UPPER_MASK;  // R11
        end else if (w_strb0_r && w_idx == `POID_IDX_LOWER) begin
          lower_r <= w_data_r[7:0];  // R11
        end
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Read channel
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h00000000;
      S_AXI_RRESP_OUT   <= `POID_RESP_OKAY;
    end else begin
      S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !do_rd;
      if (do_rd) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT  <= `POID_RESP_OKAY;
        if (r_idx == `POID_IDX_UPPER) begin
          S_AXI_RDATA_OUT <= {24'h000000, upper_r};  // R11
        end else if (r_idx == `POID_IDX_LOWER) begin
          S_AXI_RDATA_OUT <= {24'h000000, lower_r};  // R11
        end else if (r_idx == `POID_IDX_IDENT) begin
          S_AXI_RDATA_OUT <= {24'h000000, PART_ID, REV_ID};  // R9 R10
        end else begin
          S_AXI_RDATA_OUT <= 32'h00000000;
          S_AXI_RRESP_OUT <= `POID_RESP_SLVERR;
        end
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Shift control toward the core, which moves every 16 MHz derived output
  poid_shift_track #(
    .W (WORD_W)
  ) u_track (
    .clk_in    (CLK_SYS_IN),
    .rstn_in   (RSTN_IN),
    .enable_in (upper_r[`POID_EN_BIT]),
    .target_in (word),
    .applied_out (applied),
    .advance_out (adv),
    .retard_out  (ret)
  );
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PHASE_SHIFT_ENABLE_OUT <= 1'b0;
      SHIFT_WORD_OUT         <= `POID_WORD_RST;
      APPLIED_SHIFT_OUT      <= `POID_WORD_RST;
      SHIFT_ADVANCE_OUT      <= 1'b0;
      SHIFT_RETARD_OUT       <= 1'b0;
    end else begin
      PHASE_SHIFT_ENABLE_OUT <= upper_r[`POID_EN_BIT];  // R1
      SHIFT_WORD_OUT         <= word;  // R2
      APPLIED_SHIFT_OUT      <= applied;  // R5
      SHIFT_ADVANCE_OUT      <= adv;  // R4
      SHIFT_RETARD_OUT       <= ret;  // R7
    end
  end
endmodule

//--- poid_regs_chk.sv
// Concurrent checks on the ports of the phase offset register bank
module poid_regs_chk #(
  parameter [3:0] PART_ID = 4'h5,
  parameter [3:0] REV_ID  = 4'h0,
  parameter       WORD_W  = 11
) (
  input wire logic              CLK_SYS_IN, RSTN_IN,
  input wire logic              S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT,
  input wire logic              S_AXI_WVALID_IN, S_AXI_WREADY_OUT,
  input wire logic              S_AXI_BVALID_OUT, S_AXI_BREADY_IN,
  input wire logic [7:0]        S_AXI_ARADDR_IN,
  input wire logic              S_AXI_ARVALID_IN, S_AXI_ARREADY_OUT,
  input wire logic [31:0]       S_AXI_RDATA_OUT,
  input wire logic              S_AXI_RVALID_OUT, S_AXI_RREADY_IN,
  input wire logic              PHASE_SHIFT_ENABLE_OUT,
  input wire logic [WORD_W-1:0] SHIFT_WORD_OUT,
  input wire logic [WORD_W-1:0] APPLIED_SHIFT_OUT
);
  // ==========================================================
  // Sequences
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence rd_taken(a);
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == a;
  endsequence
  // Word and enable quiet long enough for the tracker pipeline to drain
  sequence settled;
    (PHASE_SHIFT_ENABLE_OUT && $stable(SHIFT_WORD_OUT))[*4];
  endsequence
  // ==========================================================
  // Assertions
  chk_b_after_wr:
    assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT
      && !S_AXI_BVALID_OUT |-> ##2 S_AXI_BVALID_OUT) else $error("write response missing");
  chk_b_stands:
    assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
      else $error("write response dropped");
  chk_r_stands:
    assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT
      && $stable(S_AXI_RDATA_OUT)) else $error("read response dropped");
  chk_ident_read:
    assert property (rd_taken(8'h3C) |=> S_AXI_RDATA_OUT == {24'h0, PART_ID, REV_ID})
      else $error("ident read wrong");
  chk_upper_read:
    assert property (rd_taken(8'h18) |=> S_AXI_RDATA_OUT == {28'h0, PHASE_SHIFT_ENABLE_OUT,
      SHIFT_WORD_OUT[10:8]}) else $error("upper read wrong");
  chk_lower_read:
    assert property (rd_taken(8'h1C) |=> S_AXI_RDATA_OUT == {24'h0, SHIFT_WORD_OUT[7:0]})
      else $error("lower read wrong");
  chk_step_up:
    assert property (settled ##0 APPLIED_SHIFT_OUT < SHIFT_WORD_OUT
      |=> APPLIED_SHIFT_OUT == $past(APPLIED_SHIFT_OUT) + 11'h001) else $error("no step up");
  chk_step_down:
    assert property (settled ##0 APPLIED_SHIFT_OUT > SHIFT_WORD_OUT
      |=> APPLIED_SHIFT_OUT == $past(APPLIED_SHIFT_OUT) - 11'h001) else $error("no step down");
  chk_off_hold:
    assert property (!PHASE_SHIFT_ENABLE_OUT && APPLIED_SHIFT_OUT == 11'h000
      |=> APPLIED_SHIFT_OUT == 11'h000) else $error("shift while disabled");
endmodule
bind poid_regs poid_regs_chk #(.PART_ID(PART_ID), .REV_ID(REV_ID), .WORD_W(WORD_W)) i_chk (.*);

//--- poid_regs_tb_top.sv
// Self-checking testbench of the phase offset register bank
module poid_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [3:0] PID = 4'hA;  // Arbitrary value
  localparam [3:0] RID = 4'h3;
  logic        clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]  aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rd_d;
  logic [1:0]  rsp;
  wire         awr, wr_r, bv, arr, rv, en, adv, ret;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [10:0]  word, app;
  int          error_cnt = 0, num_checks = 0, n_adv = 0, n_ret = 0;
  always #10 clk = ~clk;
  // Step pulses are counted so that every single step is seen, not only the end value
  always @(posedge clk) begin
    if (adv === 1'b1) n_adv <= n_adv + 1;
    if (ret === 1'b1) n_ret <= n_ret + 1;
  end
  poid_regs #(.PART_ID(PID), .REV_ID(RID)) i_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .S_AXI_AWADDR_IN(aa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
    .S_AXI_ARADDR_IN(ra), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rr), .PHASE_SHIFT_ENABLE_OUT(en), .SHIFT_WORD_OUT(word),
    .APPLIED_SHIFT_OUT(app), .SHIFT_ADVANCE_OUT(adv), .SHIFT_RETARD_OUT(ret));
  // ==========================================================
  // Bus and compare tasks
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad = 1'b0, dd = 1'b0;
    @(posedge clk);
    aa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (!dd && wr_r) begin dd = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (!bv);
    rsp = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a; arv <= 1'b1; rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd_d = rdata;
    rsp = rresp;
    rr <= 1'b0;
  endtask
  // Tracker moves one step a cycle, so forty cycles cover every walk here
  task automatic wait_app(input logic [10:0] e);
    repeat (40) if (app !== e) @(posedge clk);
    check("applied shift", app, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_ident;
    rd(8'h3C); check("ident", rd_d, {24'h0, PID, RID});
    wr(8'h3C, 32'hFF); check("ident write resp", rsp, 2'b10);
    rd(8'h3C); check("ident kept", rd_d, {24'h0, PID, RID});
    rd(8'h40); check("unmapped resp", rsp, 2'b10);
  endtask
  task automatic t_regs;
    wr(8'h18, 32'hF7);
    wr(8'h1C, 32'hFF);
    rd(8'h18); check("upper", rd_d, 32'h07);
    rd(8'h1C); check("lower", rd_d, 32'hFF);
    check("word", word, 32'h7FF);
    check("enable", en, 32'h0);
    wait_app(11'h000);
    wr(8'h18, 32'h00);
    wr(8'h1C, 32'h00);
  endtask
  task automatic t_step;
    wr(8'h18, 32'h08);
    check("write resp", rsp, 32'h0);
    @(negedge clk);
    check("enable on", en, 32'h1);
    for (int i = 1; i <= 3; i++) wr(8'h1C, i);
    wait_app(11'h003);
    for (int i = 2; i >= 1; i--) wr(8'h1C, i);
    wait_app(11'h001);
    wr(8'h18, 32'h00);
    wait_app(11'h000);
    @(negedge clk);
    check("advance steps", n_adv, 32'h3);
    check("retard steps", n_ret, 32'h3);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_ident;
    t_regs;
    t_step;
    final_report;
  end
  initial begin
    #100us;
    error_cnt++;
    final_report;
  end
endmodule
